// ==== core/guc_consts.svh ====
/*
 * Register offsets, field positions, reset values and timing counts
 * for the gated up/down counter channel.
 * Assumes it is included by bare name from the design files.
 */
`ifndef GUC_CONSTS_SVH
`define GUC_CONSTS_SVH

// register byte offsets
`define GUC_OFF_CFG 12'h000
`define GUC_OFF_CMD 12'h004
`define GUC_OFF_STAT 12'h008
`define GUC_OFF_COUNT 12'h00C
`define GUC_OFF_LOAD 12'h010
`define GUC_OFF_END 12'h014
`define GUC_OFF_CMP 12'h018
`define GUC_OFF_PULSE 12'h01C
`define GUC_OFF_LATCH 12'h020

// command word bits
`define GUC_CMD_PGATE_OPEN 2
`define GUC_CMD_PGATE_CLOSE 10
`define GUC_CMD_LATCH_READ 15

// status word bits
`define GUC_ST_GATE 0
`define GUC_ST_PGATE 1
`define GUC_ST_PINGATE 2
`define GUC_ST_OUT 3
`define GUC_ST_AUTOCLOSED 4
`define GUC_ST_LATCH_NEW 13

// one-hot function codes
`define GUC_FN_ENDLESS 6'h00
`define GUC_FN_ONCE_UP 6'h01
`define GUC_FN_ONCE_DN 6'h02
`define GUC_FN_ONCE_ND 6'h04
`define GUC_FN_PER_UP 6'h08
`define GUC_FN_PER_DN 6'h10
`define GUC_FN_PER_ND 6'h20

// output modes
`define GUC_OUT_NEVER 3'h0
`define GUC_OUT_GE 3'h1
`define GUC_OUT_LE 3'h2
`define GUC_OUT_EQ 3'h4

// reset values
`define GUC_CFG_RESET 13'h0000
`define GUC_WORD_RESET 32'h00000000
`define GUC_PULSE_RESET 8'h00

// timing
`define GUC_CLK_PERIOD_PS 20000
`define GUC_PULSE_UNIT_PS 2048000000

`endif

// ==== core/guc_pkg.sv ====
/*
 * Types for the gated up/down counter channel.
 * Assumes guc_consts.svh is available on the include path.
 */
package guc_pkg;

  typedef enum logic [1:0] {
    GUC_RUN_ENDLESS,
    GUC_RUN_ONCE,
    GUC_RUN_PERIODIC
  } guc_run_e;

  typedef enum logic [1:0] {
    GUC_DIR_NONE,
    GUC_DIR_UP,
    GUC_DIR_DOWN
  } guc_main_dir_e;

  // configuration register layout, msb first
  typedef struct packed {
    logic man_out;
    logic dir_inv;
    logic [2:0] out_mode;
    logic gate_int;
    logic pin_use;
    logic [5:0] func;
  } guc_cfg_s;

endpackage

// ==== core/guc_counter.sv ====
/*
 * One channel of a 32-bit signed up/down counter with combined gate,
 * latch capture and comparison output, behind an APB slave.
 * Assumes pulse/direction pins arrive asynchronous to core_clk_i, each
 * pulse lasting several clocks; APB master on core_clk_i.
 */
// Notes on behaviour
// RULE1: endless: up past max wraps to min
// RULE2: endless: down past min wraps to max
// RULE3: main up: reload at step past end-1
// RULE4: main down: reload at step past end+1
// RULE5: abort: reopening gate restarts at load value
// RULE6: interrupt: reopening gate resumes held value
// RULE7: once undirected: wrap and close gate
// RULE8: once up: reload and close gate
// RULE9: once down: reload and close gate
// RULE10: other side gives gate edge to rerun
// RULE11: auto-closed gate reopens on two conditions
// RULE12: periodic: wrap or reload, never close
// RULE13: periodic down: reload, upper limit exceedable
// RULE14: command bit 2 opens, bit 10 closes
// RULE15: combined gate is program and pin gate
// RULE16: program-only gate: restart or continue by behaviour
// RULE17: both gates: program edge continues, pin per behaviour
// RULE18: latch edge copies counter value
// RULE19: latch sets flag; read bit shows, clears
// RULE20: ge mode: output while count >= compare
// RULE21: le mode level; never mode manual output
// RULE22: equal mode pulse; zero width holds equality
// RULE23: main direction: only reach from that direction
// RULE24: pulse in 2.048 ms units from assertion
// RULE25: running pulse never retriggered
// RULE26: one-hot six-bit function field selects mode
// RULE27: behaviour bit: zero abort, one interrupt
// RULE28: all values and compares signed 32-bit
// RULE29: each pulse steps exactly one
`timescale 1ns/1ps
`include "guc_consts.svh"

module guc_counter
  import guc_pkg::*;
#(
  parameter int PULSE_UNIT_CYC = `GUC_PULSE_UNIT_PS / `GUC_CLK_PERIOD_PS
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic enc_pulse_i,
  input wire logic enc_dir_i,
  input wire logic gate_pin_i,
  input wire logic latch_pin_i,
  output logic cnt_out_o
);

  localparam int PW = $clog2(PULSE_UNIT_CYC + 1);
  localparam logic signed [31:0] MAXV = 32'sh7FFFFFFF;
  localparam logic signed [31:0] MINV = 32'sh80000000;

  guc_cfg_s cfg_q;
  logic signed [31:0] cnt_q, load_q, end_q, cmp_q, latch_q, image_q;
  logic [7:0] pulse_q;
  logic pgate_q, auto_closed_q, pin_seen_q, latch_new_q, out_q;
  logic gate_q, pgate_prev_q, reopened_q;
  logic [PW-1:0] pre_q;
  logic [7:0] units_q;
  logic pulse_busy_q;

  // three-stage synchronisers, change taken when stages two and three agree
  logic [3:0] pins, s1_q, s2_q, s3_q, filt_q, filt_prev_q;
  assign pins = {latch_pin_i, gate_pin_i, enc_dir_i, enc_pulse_i};

  for (genvar g = 0; g < 4; g++) begin : g_sync
    always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
        s1_q[g] <= 1'b0;
        s2_q[g] <= 1'b0;
        s3_q[g] <= 1'b0;
        filt_q[g] <= 1'b0;
        filt_prev_q[g] <= 1'b0;
      end else if (ce_i) begin
        s1_q[g] <= pins[g];
        s2_q[g] <= s1_q[g];
        s3_q[g] <= s2_q[g];
        if (s2_q[g] == s3_q[g]) begin
          filt_q[g] <= s3_q[g];
        end
        filt_prev_q[g] <= filt_q[g];
      end
    end
  end

  logic pulse_rise, pin_gate, pin_rise, latch_rise;
  assign pulse_rise = filt_q[0] & ~filt_prev_q[0];
  assign pin_gate = filt_q[2];
  assign pin_rise = filt_q[2] & ~filt_prev_q[2];
  assign latch_rise = filt_q[3] & ~filt_prev_q[3];

  // APB access decode
  logic wr_en, rd_en, mapped;
  assign wr_en = psel_i & penable_i & pwrite_i;
  assign rd_en = psel_i & penable_i & ~pwrite_i;
  assign pready_o = 1'b1;

  always_comb begin
    mapped = 1'b1;
    prdata_o = 32'h00000000;
    unique case (paddr_i)
      `GUC_OFF_CFG: prdata_o = {19'h00000, cfg_q};
      `GUC_OFF_CMD: prdata_o = 32'h00000000;
      `GUC_OFF_STAT: begin
        prdata_o[`GUC_ST_GATE] = gate_q;
        prdata_o[`GUC_ST_PGATE] = pgate_q;
        prdata_o[`GUC_ST_PINGATE] = pin_gate;
        prdata_o[`GUC_ST_OUT] = cnt_out_o;
        prdata_o[`GUC_ST_AUTOCLOSED] = auto_closed_q;
        prdata_o[`GUC_ST_LATCH_NEW] = latch_new_q;
      end
      `GUC_OFF_COUNT: prdata_o = cnt_q;
      `GUC_OFF_LOAD: prdata_o = load_q;
      `GUC_OFF_END: prdata_o = end_q;
      `GUC_OFF_CMP: prdata_o = cmp_q;
      `GUC_OFF_PULSE: prdata_o = {24'h000000, pulse_q};
      `GUC_OFF_LATCH: prdata_o = image_q;
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr_o = psel_i & penable_i & ~mapped;

  logic cmd_wr;
  assign cmd_wr = wr_en && (paddr_i == `GUC_OFF_CMD);

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      cfg_q <= `GUC_CFG_RESET;
      load_q <= `GUC_WORD_RESET;
      end_q <= `GUC_WORD_RESET;
      cmp_q <= `GUC_WORD_RESET;
      pulse_q <= `GUC_PULSE_RESET;
    end else if (ce_i && wr_en) begin
      unique case (paddr_i)
        `GUC_OFF_CFG: cfg_q <= pwdata_i[12:0];
        `GUC_OFF_LOAD: load_q <= pwdata_i;
        `GUC_OFF_END: end_q <= pwdata_i;
        `GUC_OFF_CMP: cmp_q <= pwdata_i;
        `GUC_OFF_PULSE: pulse_q <= pwdata_i[7:0];
        default: ;
      endcase
    end
  end

  // function field decode
  guc_run_e run;
  guc_main_dir_e mdir;
  always_comb begin
    unique case (cfg_q.func) // [RULE26]
      `GUC_FN_ONCE_UP: begin run = GUC_RUN_ONCE; mdir = GUC_DIR_UP; end
      `GUC_FN_ONCE_DN: begin run = GUC_RUN_ONCE; mdir = GUC_DIR_DOWN; end
      `GUC_FN_ONCE_ND: begin run = GUC_RUN_ONCE; mdir = GUC_DIR_NONE; end
      `GUC_FN_PER_UP: begin run = GUC_RUN_PERIODIC; mdir = GUC_DIR_UP; end
      `GUC_FN_PER_DN: begin run = GUC_RUN_PERIODIC; mdir = GUC_DIR_DOWN; end
      `GUC_FN_PER_ND: begin run = GUC_RUN_PERIODIC; mdir = GUC_DIR_NONE; end
      default: begin run = GUC_RUN_ENDLESS; mdir = GUC_DIR_NONE; end
    endcase
  end

  // program gate and combined gate
  logic pg_open, pg_close, pg_rise, gate_comb, gate_rise, restart_load;
  assign pg_open = cmd_wr & pwdata_i[`GUC_CMD_PGATE_OPEN];
  assign pg_close = cmd_wr & pwdata_i[`GUC_CMD_PGATE_CLOSE];
  assign pg_rise = pgate_q & ~pgate_prev_q;
  assign gate_comb = pgate_q & (pin_gate | ~cfg_q.pin_use) & ~auto_closed_q; // [RULE15]
  assign gate_rise = gate_comb & ~gate_q;

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      pgate_q <= 1'b0;
      pgate_prev_q <= 1'b0;
      gate_q <= 1'b0;
    end else if (ce_i) begin
      if (pg_close) begin
        pgate_q <= 1'b0; // [RULE14]
      end else if (pg_open) begin
        pgate_q <= 1'b1; // [RULE14]
      end
      pgate_prev_q <= pgate_q;
      gate_q <= gate_comb;
    end
  end

  // reopen case: pin rise when program gate high, program rise after pin rise [RULE11]
  logic reopen;
  assign reopen = cfg_q.pin_use ? ((pin_rise & pgate_q) | (pg_rise & pin_seen_q)) : pg_rise;

  // abort reloads; interrupt continues; program edge continues when pin gate used
  always_comb begin
    restart_load = 1'b0;
    if (gate_rise) begin
      if (!cfg_q.gate_int) begin // [RULE27]
        restart_load = reopened_q | (cfg_q.pin_use ? pin_rise : pg_rise); // [RULE16] [RULE17]
      end
      if (run == GUC_RUN_ONCE && mdir != GUC_DIR_NONE && reopened_q) begin
        restart_load = 1'b1; // [RULE8] [RULE9]
      end
    end
  end

  // count step and next value
  logic step, dn;
  logic signed [31:0] cnt_d;
  logic term;
  assign step = pulse_rise & gate_comb & ~restart_load;
  assign dn = filt_q[1] ^ cfg_q.dir_inv;

  always_comb begin
    cnt_d = cnt_q;
    term = 1'b0;
    if (restart_load) begin
      cnt_d = load_q; // [RULE5]
    end else if (step) begin
      if (mdir == GUC_DIR_UP && !dn && cnt_q == end_q - 32'sd1) begin
        cnt_d = load_q; // [RULE3] [RULE12]
        term = 1'b1;
      end else if (mdir == GUC_DIR_DOWN && dn && cnt_q == end_q + 32'sd1) begin
        cnt_d = load_q; // [RULE4] [RULE13]
        term = 1'b1;
      end else if (dn) begin
        cnt_d = cnt_q - 32'sd1; // [RULE2] [RULE29]
        term = (mdir == GUC_DIR_NONE) && (cnt_q == MINV);
      end else begin
        cnt_d = cnt_q + 32'sd1; // [RULE1] [RULE29]
        term = (mdir == GUC_DIR_NONE) && (cnt_q == MAXV);
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      cnt_q <= `GUC_WORD_RESET;
    end else if (ce_i) begin
      cnt_q <= cnt_d; // [RULE6]
    end
  end

  // automatic close in single-run mode, periodic never closes
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      auto_closed_q <= 1'b0;
      pin_seen_q <= 1'b0;
      reopened_q <= 1'b0;
    end else if (ce_i) begin
      // gate opens one cycle after the reopen edge; restart decided then
      reopened_q <= auto_closed_q & reopen;
      if (term && run == GUC_RUN_ONCE) begin
        auto_closed_q <= 1'b1; // [RULE7] [RULE8] [RULE9] [RULE12]
        pin_seen_q <= 1'b0;
      end else begin
        if (auto_closed_q && reopen) begin
          auto_closed_q <= 1'b0; // [RULE11]
        end
        if (pin_rise) begin
          pin_seen_q <= 1'b1;
        end
      end
    end
  end

  // latch capture and read-out, new capture wins over clear
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      latch_q <= `GUC_WORD_RESET;
      image_q <= `GUC_WORD_RESET;
      latch_new_q <= 1'b0;
    end else if (ce_i) begin
      if (latch_rise && gate_comb) begin
        latch_q <= cnt_q; // [RULE18]
        latch_new_q <= 1'b1; // [RULE19]
      end else if (cmd_wr && pwdata_i[`GUC_CMD_LATCH_READ]) begin
        latch_new_q <= 1'b0; // [RULE19]
      end
      if (cmd_wr && pwdata_i[`GUC_CMD_LATCH_READ]) begin
        image_q <= latch_q; // [RULE19]
      end
    end
  end

  // comparison: reach from the main direction only
  logic hit, dir_ok;
  assign dir_ok = (mdir == GUC_DIR_NONE) || ((mdir == GUC_DIR_DOWN) == dn); // [RULE23]
  assign hit = step && dir_ok && (cnt_d == cmp_q);

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      out_q <= 1'b0;
      pulse_busy_q <= 1'b0;
      pre_q <= '0;
      units_q <= 8'h00;
    end else if (ce_i) begin
      unique case (cfg_q.out_mode)
        `GUC_OUT_GE: out_q <= (cnt_d >= cmp_q); // [RULE20] [RULE28]
        `GUC_OUT_LE: out_q <= (cnt_d <= cmp_q); // [RULE21] [RULE28]
        `GUC_OUT_EQ: begin
          if (pulse_q == 8'h00) begin
            if (hit) begin
              out_q <= 1'b1; // [RULE22]
            end else if (cnt_d != cmp_q) begin
              out_q <= 1'b0;
            end
          end else if (pulse_busy_q) begin
            if (pre_q == PW'(PULSE_UNIT_CYC - 1)) begin // [RULE24]
              pre_q <= '0;
              units_q <= units_q - 8'h01;
              if (units_q == 8'h01) begin
                pulse_busy_q <= 1'b0;
                out_q <= 1'b0;
              end
            end else begin
              pre_q <= pre_q + PW'(1);
            end
          end else if (hit) begin
            pulse_busy_q <= 1'b1; // [RULE25]
            out_q <= 1'b1; // [RULE22]
            pre_q <= '0; // [RULE24]
            units_q <= pulse_q;
          end else begin
            out_q <= 1'b0;
          end
        end
        default: out_q <= cfg_q.man_out; // [RULE21]
      endcase
      if (cfg_q.out_mode != `GUC_OUT_EQ) begin
        pulse_busy_q <= 1'b0;
      end
    end
  end
  assign cnt_out_o = out_q;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  wrap_up_a: assert property (ce_i && step && !dn && run == GUC_RUN_ENDLESS && cnt_q == MAXV // [RULE1]
    |=> cnt_q == MINV) else $error("endless up wrap failed");
  wrap_down_a: assert property (ce_i && step && dn && run == GUC_RUN_ENDLESS && cnt_q == MINV // [RULE2]
    |=> cnt_q == MAXV) else $error("endless down wrap failed");
  reload_up_a: assert property (ce_i && step && !dn && mdir == GUC_DIR_UP && cnt_q == end_q - 32'sd1 // [RULE3]
    |=> cnt_q == $past(load_q)) else $error("upward reload missing");
  reload_down_a: assert property (ce_i && step && dn && mdir == GUC_DIR_DOWN && cnt_q == end_q + 32'sd1 // [RULE4]
    |=> cnt_q == $past(load_q)) else $error("downward reload missing");
  once_close_a: assert property (ce_i && term && run == GUC_RUN_ONCE // [RULE8]
    |=> auto_closed_q ##1 !gate_q) else $error("single run did not close gate");
  periodic_open_a: assert property (ce_i && term && run == GUC_RUN_PERIODIC // [RULE12]
    |=> !auto_closed_q) else $error("periodic run closed gate");
  step_one_a: assert property (ce_i && step && !term && !dn // [RULE29]
    |=> cnt_q == $past(cnt_q) + 32'sd1) else $error("count step not one");
  latch_copy_a: assert property (ce_i && latch_rise && gate_comb // [RULE18]
    |=> latch_q == $past(cnt_q) && latch_new_q) else $error("latch capture wrong");
  latch_read_a: assert property (ce_i && cmd_wr && pwdata_i[`GUC_CMD_LATCH_READ] && !latch_rise // [RULE19]
    |=> !latch_new_q && image_q == $past(latch_q)) else $error("latch read-out wrong");
  ge_level_a: assert property (ce_i && cfg_q.out_mode == `GUC_OUT_GE // [RULE20]
    |=> cnt_out_o == ($past(cnt_d) >= $past(cmp_q))) else $error("ge output wrong");
  no_retrig_a: assert property (ce_i && pulse_busy_q && hit && units_q > 8'h01 // [RULE25]
    |=> pulse_busy_q && units_q <= $past(units_q)) else $error("pulse retriggered");

  wrap_cover_c: cover property (step && run == GUC_RUN_ENDLESS && cnt_q == MAXV);
  once_cover_c: cover property (term && run == GUC_RUN_ONCE ##[1:50] reopen);
  pulse_cover_c: cover property (pulse_busy_q && units_q == 8'h01 ##1 !pulse_busy_q);
  latch_cover_c: cover property (latch_rise && gate_comb);

endmodule

// ==== tb/guc_pin_model.sv ====
/*
 * Far-side model of the counter channel: encoder pulse and direction,
 * gate pin and latch pin. The bench calls its tasks right after a rising
 * clock edge, and each task returns right after a rising edge.
 */
`timescale 1ns/1ps

module guc_pin_model (
  input wire logic core_clk_i,
  output logic enc_pulse_o,
  output logic enc_dir_o,
  output logic gate_o,
  output logic latch_o
);
  initial begin
    enc_pulse_o = 1'b0;
    enc_dir_o = 1'b0;
    gate_o = 1'b0;
    latch_o = 1'b0;
  end

  // direction settles 4 clocks before the rise; levels held 6 clocks
  task automatic step(input logic down);
    enc_dir_o <= down;
    repeat (4) @(posedge core_clk_i);
    enc_pulse_o <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    enc_pulse_o <= 1'b0;
    repeat (6) @(posedge core_clk_i);
  endtask

  // a rising edge here starts a new run when the pin gate is in use with abort behaviour
  task automatic gate(input logic v);
    gate_o <= v;
    repeat (8) @(posedge core_clk_i);
  endtask

  task automatic latch_hit();
    latch_o <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    latch_o <= 1'b0;
    repeat (6) @(posedge core_clk_i);
  endtask
endmodule

// ==== tb/test_gated_updown_counter_compare.sv ====
/*
 * Self-checking bench for the counter channel: APB access tasks and
 * sequences of calls with expected values.
 * Assumes guc_pkg, guc_consts.svh and guc_counter are compiled first.
 */
`timescale 1ns/1ps
`include "guc_consts.svh"

`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end

module test_gated_updown_counter_compare
  import guc_pkg::*;
;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic enc_pulse;
  logic enc_dir;
  logic gate_pin;
  logic latch_pin;
  logic cnt_out;
  logic [31:0] q;
  logic e;
  int n_fail = 0;
  int num_checks = 0;

  always #10 core_clk = ~core_clk;

  guc_counter #(.PULSE_UNIT_CYC(4)) guc_counter_i (
    .core_clk_i(core_clk), .reset_n_i(reset_n), .ce_i(ce),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .enc_pulse_i(enc_pulse), .enc_dir_i(enc_dir), .gate_pin_i(gate_pin),
    .latch_pin_i(latch_pin), .cnt_out_o(cnt_out)
  );

  guc_pin_model guc_pin_model_i (
    .core_clk_i(core_clk), .enc_pulse_o(enc_pulse), .enc_dir_o(enc_dir),
    .gate_o(gate_pin), .latch_o(latch_pin)
  );

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // one transfer; request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h00000000);
    `CHK(nm, x, q)
  endtask

  function automatic logic [31:0] cfg(input logic [5:0] fn, input logic pin,
                                      input logic gi, input logic [2:0] md);
    return {21'h000000, md, gi, pin, fn};
  endfunction

  initial begin
    repeat (5000) @(posedge core_clk);
    n_fail++;
    complete_run();
  end

  initial begin
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    // reset values and an unmapped address
    rchk("cfg", `GUC_OFF_CFG, 32'h00000000);
    rchk("count", `GUC_OFF_COUNT, 32'h00000000);
    rchk("stat", `GUC_OFF_STAT, 32'h00000000);
    rchk("unmapped", 12'h024, 32'h00000000);
    `CHK("slverr", 1'b1, e)
    `CHK("out rst", 1'b0, cnt_out)
    $display("test reset done");
    // endless, program gate only, abort, ge against zero
    wr(`GUC_OFF_LOAD, 32'h7FFFFFFF);
    wr(`GUC_OFF_CFG, cfg(`GUC_FN_ENDLESS, 1'b0, 1'b0, `GUC_OUT_GE));
    wr(`GUC_OFF_CMD, 32'h1 << `GUC_CMD_PGATE_OPEN);
    rchk("load start", `GUC_OFF_COUNT, 32'h7FFFFFFF);
    `CHK("ge high", 1'b1, cnt_out)
    guc_pin_model_i.step(1'b0);
    rchk("wrap up", `GUC_OFF_COUNT, 32'h80000000);
    `CHK("ge signed", 1'b0, cnt_out)
    guc_pin_model_i.latch_hit();
    apb(1'b0, `GUC_OFF_STAT, 32'h00000000);
    `CHK("latch new", 1'b1, q[`GUC_ST_LATCH_NEW])
    wr(`GUC_OFF_CMD, 32'h1 << `GUC_CMD_LATCH_READ);
    rchk("latch", `GUC_OFF_LATCH, 32'h80000000);
    apb(1'b0, `GUC_OFF_STAT, 32'h00000000);
    `CHK("latch clr", 1'b0, q[`GUC_ST_LATCH_NEW])
    guc_pin_model_i.step(1'b1);
    rchk("wrap down", `GUC_OFF_COUNT, 32'h7FFFFFFF);
    $display("test endless done");
    // interrupt behaviour keeps the held value
    wr(`GUC_OFF_CFG, cfg(`GUC_FN_ENDLESS, 1'b0, 1'b1, `GUC_OUT_NEVER));
    guc_pin_model_i.step(1'b1);
    wr(`GUC_OFF_CMD, 32'h1 << `GUC_CMD_PGATE_CLOSE);
    guc_pin_model_i.step(1'b1);
    wr(`GUC_OFF_CMD, 32'h1 << `GUC_CMD_PGATE_OPEN);
    rchk("resume", `GUC_OFF_COUNT, 32'h7FFFFFFE);
    $display("test interrupt done");
    // once upward, le against the load value
    wr(`GUC_OFF_LOAD, 32'h00000005);
    wr(`GUC_OFF_END, 32'h00000007);
    wr(`GUC_OFF_CMP, 32'h00000005);
    wr(`GUC_OFF_CFG, cfg(`GUC_FN_ONCE_UP, 1'b0, 1'b0, `GUC_OUT_LE));
    wr(`GUC_OFF_CMD, 32'h1 << `GUC_CMD_PGATE_CLOSE);
    wr(`GUC_OFF_CMD, 32'h1 << `GUC_CMD_PGATE_OPEN);
    rchk("abort", `GUC_OFF_COUNT, 32'h00000005);
    `CHK("le high", 1'b1, cnt_out)
    guc_pin_model_i.step(1'b0);
    rchk("step", `GUC_OFF_COUNT, 32'h00000006);
    `CHK("le low", 1'b0, cnt_out)
    guc_pin_model_i.step(1'b0);
    rchk("once reload", `GUC_OFF_COUNT, 32'h00000005);
    apb(1'b0, `GUC_OFF_STAT, 32'h00000000);
    `CHK("auto close", 1'b0, q[`GUC_ST_GATE])
    guc_pin_model_i.step(1'b0);
    rchk("closed", `GUC_OFF_COUNT, 32'h00000005);
    $display("test once done");
    // periodic downward with the pin gate in use
    wr(`GUC_OFF_LOAD, 32'h00000003);
    wr(`GUC_OFF_END, 32'h00000001);
    wr(`GUC_OFF_CFG, cfg(`GUC_FN_PER_DN, 1'b1, 1'b0, `GUC_OUT_NEVER));
    guc_pin_model_i.gate(1'b1);
    rchk("pin start", `GUC_OFF_COUNT, 32'h00000003);
    guc_pin_model_i.step(1'b1);
    guc_pin_model_i.step(1'b1);
    rchk("per reload", `GUC_OFF_COUNT, 32'h00000003);
    apb(1'b0, `GUC_OFF_STAT, 32'h00000000);
    `CHK("per open", 1'b1, q[`GUC_ST_GATE])
    guc_pin_model_i.gate(1'b0);
    guc_pin_model_i.step(1'b1);
    rchk("pin closed", `GUC_OFF_COUNT, 32'h00000003);
    $display("test periodic done");
    // pulse at comparison, three units of four clocks
    wr(`GUC_OFF_CFG, cfg(`GUC_FN_ENDLESS, 1'b1, 1'b0, `GUC_OUT_EQ));
    wr(`GUC_OFF_PULSE, 32'h00000003);
    wr(`GUC_OFF_CMP, 32'h00000004);
    guc_pin_model_i.gate(1'b1);
    guc_pin_model_i.step(1'b0);
    `CHK("pulse on", 1'b1, cnt_out)
    repeat (10) @(posedge core_clk);
    `CHK("pulse off", 1'b0, cnt_out)
    rchk("eq count", `GUC_OFF_COUNT, 32'h00000004);
    // pins ignored while the clock enable is low
    ce <= 1'b0;
    guc_pin_model_i.step(1'b0);
    ce <= 1'b1;
    rchk("frozen", `GUC_OFF_COUNT, 32'h00000004);
    $display("test compare done");
    // once downward, inverted direction, manual output level
    wr(`GUC_OFF_LOAD, 32'h00000003);
    wr(`GUC_OFF_END, 32'h00000001);
    wr(`GUC_OFF_CFG, cfg(`GUC_FN_ONCE_DN, 1'b0, 1'b0, `GUC_OUT_NEVER) | 32'h00001800);
    wr(`GUC_OFF_CMD, 32'h1 << `GUC_CMD_PGATE_CLOSE);
    wr(`GUC_OFF_CMD, 32'h1 << `GUC_CMD_PGATE_OPEN);
    `CHK("manual out", 1'b1, cnt_out)
    guc_pin_model_i.step(1'b0);
    rchk("inverted", `GUC_OFF_COUNT, 32'h00000002);
    guc_pin_model_i.step(1'b0);
    rchk("down reload", `GUC_OFF_COUNT, 32'h00000003);
    apb(1'b0, `GUC_OFF_STAT, 32'h00000000);
    `CHK("down close", 1'b0, q[`GUC_ST_GATE])
    wr(`GUC_OFF_CMD, 32'h1 << `GUC_CMD_PGATE_CLOSE);
    wr(`GUC_OFF_CMD, 32'h1 << `GUC_CMD_PGATE_OPEN);
    guc_pin_model_i.step(1'b0);
    rchk("rerun", `GUC_OFF_COUNT, 32'h00000002);
    $display("test once down done");
    // reset in mid-run
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    rchk("count rst", `GUC_OFF_COUNT, 32'h00000000);
    `CHK("out rst2", 1'b0, cnt_out)
    $display("test reset again done");
    complete_run();
  end
endmodule
